// *** verilog/fotc_top.sv ***
// flash timing and option configuration with an AXI4-Lite register slave
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module fotc_top (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // write address channel
    input wire logic [fotc_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [fotc_pkg::AXI_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [fotc_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [fotc_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // nonvolatile loads at power-up
    input wire logic opt_load,
    input wire logic [7:0] opt_load_data,
    input wire logic trim_load,
    input wire logic [7:0] trim_load_data,
    // memory controller handshake
    input wire logic op_start,
    output logic op_go,
    output logic [15:0] op_timing,
    // timing configuration
    output logic [15:0] mem_timing_value,
    output logic timing_in_range,
    // oscillator and protection
    output fotc_pkg::fotc_osc_type oscillator_mode_field,
    output logic write_protect_option,
    // clock glitch filter
    output fotc_pkg::fotc_flt_type clock_glitch_filter,
    output logic flt_low_en,
    output logic flt_high_en,
    output logic [2:0] filter_delay_control,
    output logic [4:0] filter_width_ns
);
    import fotc_pkg::*;

    // write address holding stage
    logic aw_full_q;
    logic [IDX_W-1:0] aw_idx_q;
    // write data holding stage, only lane 0 matters
    logic w_full_q;
    logic [7:0] w_data_q;
    logic w_strb0_q;
    // write response
    logic bvalid_q;
    logic [1:0] bresp_q;
    // read response
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [AXI_DW-1:0] rdata_q;
    // timing latched at operation start
    logic [15:0] op_timing_q;

    // stored bytes
    logic [7:0] opt_q;
    logic [7:0] trim_q;
    logic [7:0] tmh_q;
    logic [7:0] tml_q;

    // handshakes
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire rd_hs = s_axi_arvalid && s_axi_arready;
    // write fires once address and data are both held
    wire do_wr = aw_full_q && w_full_q && !bvalid_q;
    // a write only lands when byte lane 0 is enabled
    wire wr_en = do_wr && w_strb0_q;

    // write decode
    wire wr_opt = wr_en && (aw_idx_q == IDX_OPT0);
    wire wr_trim = wr_en && (aw_idx_q == IDX_TRIM);
    wire wr_tmh = wr_en && (aw_idx_q == IDX_TMH);
    wire wr_tml = wr_en && (aw_idx_q == IDX_TML);
    // second option byte and status are mapped but read-only
    wire wr_mapped = (aw_idx_q == IDX_OPT0) || (aw_idx_q == IDX_OPT1)
        || (aw_idx_q == IDX_STAT) || (aw_idx_q == IDX_TRIM)
        || (aw_idx_q == IDX_TMH) || (aw_idx_q == IDX_TML);

    // read decode
    wire [IDX_W-1:0] rd_idx = s_axi_araddr[AXI_AW-1:2];
    wire rd_opt0 = rd_idx == IDX_OPT0;
    wire rd_opt1 = rd_idx == IDX_OPT1;
    wire rd_stat = rd_idx == IDX_STAT;
    wire rd_trim = rd_idx == IDX_TRIM;
    wire rd_tmh = rd_idx == IDX_TMH;
    wire rd_tml = rd_idx == IDX_TML;
    wire rd_mapped = rd_opt0 || rd_opt1 || rd_stat || rd_trim || rd_tmh
        || rd_tml;

    // erased option byte
    wire opt_erased = opt_q == OPT_ERASED;
    // status byte for software
    wire [7:0] stat_byte = {filter_width_ns, opt_erased, timing_in_range,
        write_protect_option};
    // read mux, second option byte reads zero (see RQ6)
    wire [7:0] rd_byte = rd_opt0 ? opt_q :
                         rd_stat ? stat_byte :
                         rd_trim ? trim_q :
                         rd_tmh ? tmh_q :
                         rd_tml ? tml_q : REG_RST;
    wire [AXI_DW-1:0] rd_word = {{(AXI_DW-8){1'b0}}, rd_byte};

    // channel readies: one write and one read in flight
    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready = !w_full_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    // response outputs from flops
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // timing value, high byte on top (see RQ1)
    assign mem_timing_value = {tmh_q, tml_q};
    // advisory range flag for software (see RQ3)
    assign timing_in_range = (mem_timing_value >= FREQ_MIN_KHZ)
        && (mem_timing_value <= FREQ_MAX_KHZ);
    // operation allowed only when protection bit is set (see RQ13)
    assign op_go = op_start && write_protect_option;
    assign op_timing = op_timing_q;

    // write address capture
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            aw_full_q <= 1'b0;
            aw_idx_q <= '0;
        end else if (aw_hs) begin
            aw_full_q <= 1'b1;
            aw_idx_q <= s_axi_awaddr[AXI_AW-1:2];
        end else if (do_wr) begin
            aw_full_q <= 1'b0;
        end
    end

    // write data capture
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            w_full_q <= 1'b0;
            w_data_q <= REG_RST;
            w_strb0_q <= 1'b0;
        end else if (w_hs) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_strb0_q <= s_axi_wstrb[0];
        end else if (do_wr) begin
            w_full_q <= 1'b0;
        end
    end

    // write response, error on unmapped index
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // read response, error on unmapped index
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else if (rd_hs) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // live timing bytes taken at start, no commit step (see RQ14)
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            op_timing_q <= '0;
        end else if (op_start) begin
            op_timing_q <= mem_timing_value;
        end
    end

    // option byte, no reset term at all (see RQ7) (see RQ6)
    fotc_byte_reg #(.RST_EN(1'b0), .INIT(OPT_ERASED)) u_opt (
        .mclk(mclk),
        .rstn(rstn),
        .we(wr_opt),
        .wd(w_data_q),
        .ld(opt_load),
        .ld_d(opt_load_data),
        .q(opt_q)
    );

    // trim byte, reset zero, factory load (see RQ5) (see RQ12)
    fotc_byte_reg #(.RST_EN(1'b1), .INIT(REG_RST)) u_trim (
        .mclk(mclk),
        .rstn(rstn),
        .we(wr_trim),
        .wd(w_data_q),
        .ld(trim_load),
        .ld_d(trim_load_data),
        .q(trim_q)
    );

    // timing high byte (see RQ4)
    fotc_byte_reg #(.RST_EN(1'b1), .INIT(REG_RST)) u_tmh (
        .mclk(mclk),
        .rstn(rstn),
        .we(wr_tmh),
        .wd(w_data_q),
        .ld(1'b0),
        .ld_d(REG_RST),
        .q(tmh_q)
    );

    // timing low byte (see RQ4)
    fotc_byte_reg #(.RST_EN(1'b1), .INIT(REG_RST)) u_tml (
        .mclk(mclk),
        .rstn(rstn),
        .we(wr_tml),
        .wd(w_data_q),
        .ld(1'b0),
        .ld_d(REG_RST),
        .q(tml_q)
    );

    // oscillator, protection and filter decode
    fotc_opt_decode u_dec (
        .opt(opt_q),
        .trim(trim_q),
        .osc_mode(oscillator_mode_field),
        .wp_opt(write_protect_option),
        .flt_sel(clock_glitch_filter),
        .flt_low_en(flt_low_en),
        .flt_high_en(flt_high_en),
        .dly(filter_delay_control),
        .width_ns(filter_width_ns)
    );

    // checks on the configuration outputs
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // high byte write shows in upper half next cycle
    timing_high_a: assert property ( // see RQ1
        wr_tmh |=> mem_timing_value[15:8] == $past(w_data_q)
            && mem_timing_value[7:0] == $past(tml_q))
        else $error("timing high byte not placed on top");

    // timing and trim bytes are zero once reset has had an edge
    reset_zero_a: assert property ( // see RQ4
        @(posedge mclk) disable iff (1'b0)
        !rstn && $past(!rstn) |-> tmh_q == REG_RST && tml_q == REG_RST
            && trim_q == REG_RST)
        else $error("timing or trim byte not zero in reset");

    // option byte keeps its value through reset
    opt_keep_a: assert property ( // see RQ7
        @(posedge mclk) disable iff (1'b0)
        !rstn && !opt_load |=> opt_q == $past(opt_q))
        else $error("option byte changed by reset");

    // option byte is readable at index zero
    opt_read_a: assert property ( // see RQ6
        rd_hs && rd_opt0 |=> s_axi_rvalid
            && s_axi_rdata[7:0] == $past(opt_q))
        else $error("option byte read wrong");

    // oscillator field follows a write of the option byte
    osc_mode_a: assert property ( // see RQ8
        wr_opt && !opt_load |=> oscillator_mode_field
            == fotc_osc_type'($past(w_data_q[5:4])))
        else $error("oscillator mode not decoded from bits 5:4");

    // erased option byte gives maximum power crystal
    osc_erased_a: assert property ( // see RQ9
        opt_erased |-> oscillator_mode_field == OSC_XTAL_HIGH)
        else $error("erased option byte not maximum power");

    // both filter enables only in the both mode
    flt_mode_a: assert property ( // see RQ10
        (flt_low_en && flt_high_en) == (clock_glitch_filter == FLT_BOTH)
            && (!flt_low_en && !flt_high_en)
            == (clock_glitch_filter == FLT_NONE))
        else $error("filter mode decode wrong");

    // shortest and longest delay codes
    flt_width_a: assert property ( // see RQ11
        (filter_delay_control == 3'h0 |-> filter_width_ns == 5'h05) and
        (filter_delay_control == 3'h7 |-> filter_width_ns == 5'h19))
        else $error("filter width table wrong");

    // factory trim load lands next cycle
    trim_load_a: assert property ( // see RQ12
        trim_load |=> trim_q == $past(trim_load_data))
        else $error("factory trim not loaded");

    // start passes only when the protection bit is set
    op_gate_a: assert property ( // see RQ13
        op_start |-> op_go == write_protect_option)
        else $error("operation gate does not follow protection bit");

    // start captures the current timing bytes
    op_timing_a: assert property ( // see RQ14
        op_start |=> op_timing == $past(mem_timing_value))
        else $error("operation timing not taken at start");

    // range flag bounds
    range_a: assert property ( // see RQ3
        timing_in_range |-> mem_timing_value >= FREQ_MIN_KHZ
            && mem_timing_value <= FREQ_MAX_KHZ)
        else $error("range flag set out of range");

    // main scenarios
    cv_timing_then_go: cover property (wr_tml ##[1:50] op_go);
    cv_opt_read: cover property (rd_hs && rd_opt0);
    cv_trim_load: cover property (trim_load ##1 flt_high_en);
    cv_bad_addr: cover property (do_wr && !wr_mapped);
endmodule
`default_nettype wire

// *** inc/fotc_pkg.sv ***
// constants and types of the flash timing and option config block
// Operation
// (RQ1) timing value is high byte over low
// (RQ2) software loads clock frequency in kilohertz
// (RQ3) software programs only between 10 kHz and 20 MHz
// (RQ4) timing bytes read-write, reset zero, fixed addresses
// (RQ5) trim data byte read-write, resets to zero
// (RQ6) first two program bytes hold option bits; only the first is stored here, the second reads zero and ignores writes
// (RQ7) option byte untouched by any reset
// (RQ8) option bits 5:4 select oscillator mode
// (RQ9) erased option byte selects maximum power crystal
// (RQ10) filter select picks none, low, high, both
// (RQ11) delay control maps to 5 to 25 ns
// (RQ12) filter trim comes from factory load
// (RQ13) write protect bit set enables program, erase
// (RQ14) operation start uses live timing bytes
`default_nettype none
package fotc_pkg;
    // bus shape
    localparam int AXI_AW = 14;
    localparam int AXI_DW = 32;
    localparam int IDX_W = 12;
    // register indexes, byte address is four times the index
    localparam logic [11:0] IDX_OPT0 = 12'h000;
    localparam logic [11:0] IDX_OPT1 = 12'h001;
    localparam logic [11:0] IDX_STAT = 12'hFF0;
    localparam logic [11:0] IDX_TRIM = 12'hFF7;
    localparam logic [11:0] IDX_TMH = 12'hFFA;
    localparam logic [11:0] IDX_TML = 12'hFFB;
    // responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // reset and erased values
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] OPT_ERASED = 8'hFF;
    // field positions
    localparam int OPT_WP_BIT = 0;
    localparam int OPT_OSC_LSB = 4;
    localparam int TRIM_FLT_LSB = 0;
    localparam int TRIM_DLY_LSB = 2;
    localparam int STAT_WP_BIT = 0;
    localparam int STAT_RANGE_BIT = 1;
    localparam int STAT_ERASED_BIT = 2;
    localparam int STAT_WIDTH_LSB = 3;
    // supported clock range in kilohertz
    localparam logic [15:0] FREQ_MIN_KHZ = 16'h000A;
    localparam logic [15:0] FREQ_MAX_KHZ = 16'h4E20;
    // oscillator drive modes
    typedef enum logic [1:0] {
        OSC_RC = 2'b00,
        OSC_XTAL_LOW = 2'b01,
        OSC_XTAL_MED = 2'b10,
        OSC_XTAL_HIGH = 2'b11
    } fotc_osc_type;
    // clock glitch filter modes
    typedef enum logic [1:0] {
        FLT_NONE = 2'b00,
        FLT_LOW = 2'b01,
        FLT_HIGH = 2'b10,
        FLT_BOTH = 2'b11
    } fotc_flt_type;
    // rejected glitch width in ns per delay code
    localparam logic [4:0] FLT_NS [8] = '{5'h05, 5'h07, 5'h09, 5'h0B,
        5'h0D, 5'h11, 5'h14, 5'h19};
endpackage
`default_nettype wire

// *** verilog/fotc_byte_reg.sv ***
// one byte register with software write and nonvolatile load
`timescale 1ns/1ps
`default_nettype none
module fotc_byte_reg #(
    parameter bit RST_EN = 1'b1,
    parameter logic [7:0] INIT = 8'h00
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // software write
    input wire logic we,
    input wire logic [7:0] wd,
    // nonvolatile load, wins over a write
    input wire logic ld,
    input wire logic [7:0] ld_d,
    // stored byte
    output logic [7:0] q
);
    generate
        if (RST_EN) begin : g_rst
            // cleared by reset
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    q <= INIT;
                end else if (ld) begin
                    q <= ld_d;
                end else if (we) begin
                    q <= wd;
                end
            end
        end else begin : g_keep
            // power-up value only, reset never touches it
            logic [7:0] keep_q = INIT;
            always_ff @(posedge mclk) begin
                if (ld) begin
                    keep_q <= ld_d;
                end else if (we) begin
                    keep_q <= wd;
                end
            end
            assign q = keep_q;
        end
    endgenerate
endmodule
`default_nettype wire

// *** verilog/fotc_opt_decode.sv ***
// decode of option byte and trim byte into oscillator and filter controls
`timescale 1ns/1ps
`default_nettype none
module fotc_opt_decode (
    // stored bytes
    input wire logic [7:0] opt,
    input wire logic [7:0] trim,
    // oscillator and protection
    output fotc_pkg::fotc_osc_type osc_mode,
    output logic wp_opt,
    // clock filter
    output fotc_pkg::fotc_flt_type flt_sel,
    output logic flt_low_en,
    output logic flt_high_en,
    output logic [2:0] dly,
    output logic [4:0] width_ns
);
    import fotc_pkg::*;
    // oscillator field, erased byte reads 11 (see RQ8) (see RQ9)
    assign osc_mode = fotc_osc_type'(opt[OPT_OSC_LSB+:2]);
    // program and erase enable bit (see RQ13)
    assign wp_opt = opt[OPT_WP_BIT];
    // filter mode from factory trim bits (see RQ10) (see RQ12)
    assign flt_sel = fotc_flt_type'(trim[TRIM_FLT_LSB+:2]);
    assign flt_low_en = flt_sel[0];
    assign flt_high_en = flt_sel[1];
    // same width for both polarities (see RQ11)
    assign dly = trim[TRIM_DLY_LSB+:3];
    assign width_ns = FLT_NS[dly];
endmodule
`default_nettype wire

// *** testbench/flash_timing_and_option_config_tb_top.sv ***
// self-checking bench for the flash timing and option config block
`timescale 1ns/1ps
`default_nettype none
module flash_timing_and_option_config_tb_top;
    import fotc_pkg::*;
    // clock, reset, bus
    logic mclk;
    logic rstn;
    logic [AXI_AW-1:0] s_axi_awaddr;
    logic [AXI_AW-1:0] s_axi_araddr;
    logic [AXI_DW-1:0] s_axi_wdata;
    logic [AXI_DW-1:0] s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp;
    logic [1:0] s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    // loads and controller side
    logic opt_load, trim_load, op_start, op_go;
    logic [7:0] opt_load_data;
    logic [7:0] trim_load_data;
    logic [15:0] op_timing;
    logic [15:0] mem_timing_value;
    logic timing_in_range;
    fotc_osc_type oscillator_mode_field;
    logic write_protect_option;
    fotc_flt_type clock_glitch_filter;
    logic flt_low_en, flt_high_en;
    logic [2:0] filter_delay_control;
    logic [4:0] filter_width_ns;
    // counters
    int err_count;
    int n_compared;
    // rejected glitch width per delay code
    logic [4:0] width_tbl [8] = '{5'h05, 5'h07, 5'h09, 5'h0B,
        5'h0D, 5'h11, 5'h14, 5'h19};

    fotc_top i_dut (
        .mclk(mclk), .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .opt_load(opt_load), .opt_load_data(opt_load_data),
        .trim_load(trim_load), .trim_load_data(trim_load_data),
        .op_start(op_start), .op_go(op_go), .op_timing(op_timing),
        .mem_timing_value(mem_timing_value),
        .timing_in_range(timing_in_range),
        .oscillator_mode_field(oscillator_mode_field),
        .write_protect_option(write_protect_option),
        .clock_glitch_filter(clock_glitch_filter),
        .flt_low_en(flt_low_en), .flt_high_en(flt_high_en),
        .filter_delay_control(filter_delay_control),
        .filter_width_ns(filter_width_ns)
    );

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // verdict and end of run
    task automatic end_of_test();
        $display("compared %0d, wrong %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // value compare with case equality
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    // a wait ran out
    task automatic hang();
        err_count++;
        $display("wait ran out at %0t", $time);
        end_of_test();
    endtask

    // one bus write, response compared
    task automatic bus_wr(input logic [11:0] idx, input logic [7:0] d,
            input logic [3:0] strb, input logic [1:0] exp_resp);
        int n;
        logic aw_ok;
        logic w_ok;
        logic done;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        done = 1'b0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= strb;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 40 && !done; n++) begin
            @(posedge mclk);
            // response only after both halves were taken
            if (s_axi_bvalid && aw_ok && w_ok) begin
                chk(s_axi_bresp, exp_resp);
                done = 1'b1;
            end
            if (!aw_ok && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aw_ok = 1'b1;
            end
            if (!w_ok && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w_ok = 1'b1;
            end
        end
        if (!done) hang();
    endtask

    // one bus read, low byte and response compared
    task automatic bus_rd(input logic [11:0] idx, input logic [7:0] exp_d,
            input logic [1:0] exp_resp);
        int n;
        logic ar_ok;
        logic done;
        ar_ok = 1'b0;
        done = 1'b0;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40 && !done; n++) begin
            @(posedge mclk);
            if (s_axi_rvalid && ar_ok) begin
                chk(s_axi_rresp, exp_resp);
                // data is meaningful only on an okay answer
                if (exp_resp == RESP_OKAY) chk(s_axi_rdata, {24'h0, exp_d});
                done = 1'b1;
            end
            if (!ar_ok && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                ar_ok = 1'b1;
            end
        end
        if (!done) hang();
    endtask

    // start request from the memory controller
    task automatic do_op(input logic exp_go, input logic [15:0] exp_tim);
        op_start <= 1'b1;
        @(posedge mclk);
        chk(op_go, exp_go);
        op_start <= 1'b0;
        @(posedge mclk);
        chk(op_timing, exp_tim);
    endtask

    // reset pulse held for several edges
    task automatic pulse_reset(input int cycles);
        rstn <= 1'b0;
        repeat (cycles) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
    endtask

    // power-up contents before any load
    task automatic t_power_up();
        bus_rd(IDX_OPT0, OPT_ERASED, RESP_OKAY);
        chk(oscillator_mode_field, OSC_XTAL_HIGH);
        // erased, out of range, protection bit set, shortest width
        bus_rd(IDX_STAT, 8'h2D, RESP_OKAY);
        bus_rd(IDX_TRIM, 8'h00, RESP_OKAY);
        bus_rd(IDX_TMH, 8'h00, RESP_OKAY);
        bus_rd(IDX_TML, 8'h00, RESP_OKAY);
        chk(mem_timing_value, 32'h0);
    endtask

    // timing bytes joined, range boundaries, strobe off
    task automatic t_timing();
        logic [15:0] v [4] = '{16'h4E20, 16'h4E21, 16'h000A, 16'h0009};
        logic in_rng [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            bus_wr(IDX_TMH, v[i][15:8], 4'h1, RESP_OKAY);
            bus_wr(IDX_TML, v[i][7:0], 4'h1, RESP_OKAY);
            chk(mem_timing_value, v[i]);
            chk(timing_in_range, in_rng[i]);
            bus_rd(IDX_TMH, v[i][15:8], RESP_OKAY);
            bus_rd(IDX_TML, v[i][7:0], RESP_OKAY);
        end
        // byte lane off leaves the byte alone
        bus_wr(IDX_TML, 8'hFF, 4'h0, RESP_OKAY);
        bus_rd(IDX_TML, 8'h09, RESP_OKAY);
    endtask

    // start gated by protect bit, live timing taken
    task automatic t_start();
        bus_wr(IDX_OPT0, 8'h01, 4'h1, RESP_OKAY);
        bus_wr(IDX_TMH, 8'h12, 4'h1, RESP_OKAY);
        bus_wr(IDX_TML, 8'h34, 4'h1, RESP_OKAY);
        // 4660 kHz clock: in range, protection set, trim still zero
        bus_rd(IDX_STAT, 8'h2B, RESP_OKAY);
        do_op(1'b1, 16'h1234);
        bus_wr(IDX_TML, 8'h56, 4'h1, RESP_OKAY);
        do_op(1'b1, 16'h1256);
        bus_wr(IDX_OPT0, 8'h00, 4'h1, RESP_OKAY);
        chk(write_protect_option, 1'b0);
        do_op(1'b0, 16'h1256);
    endtask

    // every oscillator mode code
    task automatic t_osc();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            bus_wr(IDX_OPT0, {2'b00, c, 3'b000, c[0]}, 4'h1,
                RESP_OKAY);
            chk(oscillator_mode_field, c);
            chk(write_protect_option, c[0]);
            bus_rd(IDX_OPT0, {2'b00, c, 3'b000, c[0]}, RESP_OKAY);
        end
    endtask

    // option byte survives reset, timing does not
    task automatic t_keep();
        bus_wr(IDX_OPT0, 8'hA5, 4'h1, RESP_OKAY);
        bus_wr(IDX_TMH, 8'h77, 4'h1, RESP_OKAY);
        pulse_reset(3);
        bus_rd(IDX_OPT0, 8'hA5, RESP_OKAY);
        chk(oscillator_mode_field, OSC_XTAL_MED);
        bus_rd(IDX_TMH, 8'h00, RESP_OKAY);
        // nonvolatile load replaces the byte
        opt_load_data <= 8'h3C;
        opt_load <= 1'b1;
        @(posedge mclk);
        opt_load <= 1'b0;
        @(posedge mclk);
        chk(oscillator_mode_field, OSC_XTAL_HIGH);
        bus_rd(IDX_OPT0, 8'h3C, RESP_OKAY);
    endtask

    // factory trim codes through the filter decode
    task automatic t_trim();
        logic [4:0] c;
        for (int i = 0; i < 32; i++) begin
            c = i[4:0];
            trim_load_data <= {3'b000, c};
            trim_load <= 1'b1;
            @(posedge mclk);
            trim_load <= 1'b0;
            @(posedge mclk);
            chk(clock_glitch_filter, c[1:0]);
            chk(flt_low_en, c[0]);
            chk(flt_high_en, c[1]);
            chk(filter_delay_control, c[4:2]);
            chk(filter_width_ns, width_tbl[c[4:2]]);
        end
        bus_wr(IDX_TRIM, 8'h5A, 4'h1, RESP_OKAY);
        bus_rd(IDX_TRIM, 8'h5A, RESP_OKAY);
    endtask

    // second option byte and an unmapped place
    task automatic t_map();
        bus_wr(IDX_OPT1, 8'h12, 4'h1, RESP_OKAY);
        bus_rd(IDX_OPT1, 8'h00, RESP_OKAY);
        bus_wr(12'h100, 8'h12, 4'h1, RESP_SLVERR);
        bus_rd(12'h100, 8'h00, RESP_SLVERR);
    endtask

    // main sequence
    initial begin
        err_count = 0;
        n_compared = 0;
        rstn = 1'b0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        opt_load = 1'b0;
        trim_load = 1'b0;
        op_start = 1'b0;
        opt_load_data = 8'h00;
        trim_load_data = 8'h00;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        t_power_up();
        t_timing();
        t_start();
        t_osc();
        t_keep();
        t_trim();
        t_map();
        end_of_test();
    end
endmodule
`default_nettype wire
